// File: src/cisd_defines.svh
/*
 fixed field positions and values of the identity and access property registers.
 assumes inclusion by the package and design files; definitions only.
*/
`ifndef CISD_DEFINES_SVH
`define CISD_DEFINES_SVH

`define CISD_REG_W          128
`define CISD_CRC_LSB        1
`define CISD_CRC_W          7
`define CISD_CRC_POLY       7'h09
`define CISD_CRC_SPAN_LSB   8
`define CISD_TARGET_CLKS_LSB 8'h0
`define CISD_SEL_IDENT      1'b0
`define CISD_SEL_PROPS      1'b1
`define CISD_SHIFT_CNT_W    8
`define CISD_SHIFT_LAST     8'h7f

`define CISD_ID_MAKER_MSB   127
`define CISD_ID_PKG_MSB     113
`define CISD_ID_OEM_MSB     111
`define CISD_ID_NAME_MSB    103
`define CISD_ID_REV_MSB     55
`define CISD_ID_SERIAL_MSB  47
`define CISD_ID_DATE_MSB    15

`define CISD_LAYOUT_VERSION 2'h3
`define CISD_STD_VERSION    4'h4
`define CISD_READ_ACC_TIME  8'h4f
`define CISD_READ_ACC_CLKS  8'h01
`define CISD_MAX_BUS_RATE   8'h32
`define CISD_CMD_CLASSES    12'h8f5
`define CISD_RD_BLK_CODE    4'h9
`define CISD_CAPACITY_FIELD 12'hfff
`define CISD_CURRENT_CODE   3'h7
`define CISD_SIZE_MULT      3'h7
`define CISD_ERASE_CNT_SML  5'h0f
`define CISD_ERASE_CNT_LRG  5'h1f
`define CISD_ERASE_MULT     5'h1f
`define CISD_PROT_GRP_SIZE  5'h0f
`define CISD_R2W_FACTOR     3'h2
`define CISD_WR_BLK_CODE    4'h9

`endif

// File: src/cisd_pkg.sv
/*
 types shared by the register bank and its checksum unit.
 assumes the defines header is on the include path.
*/
`include "cisd_defines.svh"
package cisd_pkg;
   typedef logic [`CISD_REG_W-1:0] cisd_reg_t;
   typedef logic [`CISD_CRC_W-1:0] cisd_crc_t;
   typedef enum logic [1:0] {
      CISD_IDLE  = 2'b00,
      CISD_SHIFT = 2'b01,
      CISD_DONE  = 2'b10
   } cisd_state_t;
endpackage : cisd_pkg

// File: src/cisd_crc7.sv
/*
 combinational crc7 over the upper 120 bits of a 128-bit register.
 assumes a constant input, so the loop folds to wiring at synthesis.
*/
`timescale 1ns/100ps
`default_nettype none
`include "cisd_defines.svh"
module cisd_crc7
   import cisd_pkg::*;
(
   input  wire cisd_reg_t data,
   output var  cisd_crc_t crc
);
   always_comb begin
      cisd_crc_t c;
      logic      fb;
      fb = 1'b0;
      c = '0;
      for (int i = `CISD_REG_W-1; i >= `CISD_CRC_SPAN_LSB; i--) begin
         fb = c[6] ^ data[i];
         c  = {c[5:0], 1'b0};
         if (fb) begin
            c = c ^ `CISD_CRC_POLY;
         end
      end
      crc = c;
   end
endmodule : cisd_crc7
`default_nettype wire

// File: src/cisd_regs.sv
/*
 read-only identity and access property registers, shifted out msb first on request.
 assumes command decoding elsewhere raises rd_req with rd_sel for one cycle.
*/
`timescale 1ns/100ps
`default_nettype none
`include "cisd_defines.svh"
module cisd_regs
   import cisd_pkg::*;
#(
   parameter bit          LARGE_PART  = 1'b1,
   parameter logic [7:0]  MAKER_CODE  = 8'h5a,          // arbitrary value
   parameter logic [1:0]  PKG_TYPE    = 2'h2,           // arbitrary value
   parameter logic [7:0]  OEM_CODE    = 8'h3c,          // arbitrary value
   parameter logic [47:0] PRODUCT     = 48'h41_42_43_44_45_46, // arbitrary value
   parameter logic [7:0]  REVISION    = 8'h10,          // arbitrary value
   parameter logic [31:0] SERIAL      = 32'h0000_0001,
   parameter logic [7:0]  MFG_DATE    = 8'h00
)(
   input  wire logic mclk,
   input  wire logic nrst,
   input  wire logic rd_req,
   input  wire logic rd_sel,
   input  wire logic wr_req,
   output var  logic rd_bit,
   output var  logic rd_valid,
   output var  logic rd_last,
   output var  logic busy
);
   // elaboration checks on the fixed layout
   if (`CISD_REG_W != 128) begin : g_bad_width
      $error("register width must be 128");
   end
   if (`CISD_SHIFT_LAST != `CISD_REG_W - 1) begin : g_bad_last
      $error("shift end must be the last register bit");
   end
   if (`CISD_SHIFT_CNT_W < 7) begin : g_bad_cnt
      $error("shift counter too narrow for the register");
   end

   wire cisd_reg_t ident_body = {
      MAKER_CODE,
      6'h00,
      PKG_TYPE,
      OEM_CODE,
      PRODUCT,
      REVISION,
      SERIAL,
      MFG_DATE,
      8'h00
   };

   wire logic [4:0] erase_cnt = LARGE_PART ? `CISD_ERASE_CNT_LRG : `CISD_ERASE_CNT_SML;

   wire cisd_reg_t props_body = {
      `CISD_LAYOUT_VERSION,
      `CISD_STD_VERSION,
      2'h0,
      `CISD_READ_ACC_TIME,
      `CISD_READ_ACC_CLKS,
      `CISD_MAX_BUS_RATE,
      `CISD_CMD_CLASSES,
      `CISD_RD_BLK_CODE,
      1'b0,
      3'h0,
      2'h0,
      `CISD_CAPACITY_FIELD,
      {4{`CISD_CURRENT_CODE}},
      `CISD_SIZE_MULT,
      erase_cnt,
      `CISD_ERASE_MULT,
      `CISD_PROT_GRP_SIZE,
      1'b1,
      2'h0,
      `CISD_R2W_FACTOR,
      `CISD_WR_BLK_CODE,
      1'b0,
      4'h0,
      1'b0,
      1'b0,
      1'b0,
      1'b0,
      1'b0,
      2'h0,
      2'h0,
      8'h00
   };

   wire cisd_crc_t ident_crc;
   wire cisd_crc_t props_crc;

   cisd_crc7 u_crc_ident (
      .data (ident_body),
      .crc  (ident_crc)
   );
   cisd_crc7 u_crc_props (
      .data (props_body),
      .crc  (props_crc)
   );

   wire cisd_reg_t ident_full = {ident_body[127:8], ident_crc, 1'b1};
   wire cisd_reg_t props_full = {props_body[127:8], props_crc, 1'b1};

   cisd_state_t                  state_r,  state_nxt;
   cisd_reg_t                    shreg_r,  shreg_nxt;
   logic [`CISD_SHIFT_CNT_W-1:0] cnt_r,    cnt_nxt;
   logic                         bit_r,    bit_nxt;
   logic                         valid_r,  valid_nxt;
   logic                         last_r,   last_nxt;
   logic                         busy_r,   busy_nxt;

   // true while the register is being shifted out
   function automatic logic in_shift(input cisd_state_t st);
      return (st == CISD_SHIFT);
   endfunction : in_shift

   wire logic start    = (state_r == CISD_IDLE) && rd_req;
   wire cisd_reg_t pick = (rd_sel == `CISD_SEL_PROPS) ? props_full : ident_full;
   wire logic at_last  = (cnt_r == `CISD_SHIFT_LAST);
   wire logic unused_w = wr_req;

   // next values of the registered outputs
   assign bit_nxt   = in_shift(state_r) ? shreg_r[127] : 1'b0;
   assign valid_nxt = in_shift(state_r);
   assign last_nxt  = in_shift(state_r) && at_last;
   assign busy_nxt  = (state_nxt != CISD_IDLE) | (unused_w & 1'b0);

   // idle waits, shift moves one bit a cycle
   always_comb begin
      state_nxt = state_r;
      shreg_nxt = shreg_r;
      cnt_nxt   = cnt_r;
      case (state_r)
         CISD_IDLE: begin
            if (start) begin
               shreg_nxt = pick;
               cnt_nxt   = '0;
               state_nxt = CISD_SHIFT;
            end
         end
         CISD_SHIFT: begin
            shreg_nxt = {shreg_r[126:0], 1'b0};
            cnt_nxt   = cnt_r + 8'h01;
            if (at_last) begin
               state_nxt = CISD_DONE;
            end
         end
         CISD_DONE: begin
            state_nxt = CISD_IDLE;
         end
         default: begin
            state_nxt = CISD_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         state_r <= CISD_IDLE;
         shreg_r <= '0;
         cnt_r   <= '0;
      end else begin
         state_r <= state_nxt;
         shreg_r <= shreg_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

   // registered outputs
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         bit_r   <= 1'b0;
         valid_r <= 1'b0;
         last_r  <= 1'b0;
         busy_r  <= 1'b0;
      end else begin
         bit_r   <= bit_nxt;
         valid_r <= valid_nxt;
         last_r  <= last_nxt;
         busy_r  <= busy_nxt;
      end
   end

   assign rd_bit   = bit_r;
   assign rd_valid = valid_r;
   assign rd_last  = last_r;
   assign busy     = busy_r;
endmodule : cisd_regs
`default_nettype wire

// File: verification/cisd_regs_monitor.sv
/* port checker for the register bank.
 assumes bind onto cisd_regs, one clock domain. */
`timescale 1ns/100ps
`default_nettype none
module cisd_monitor (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic rd_req,
   input wire logic rd_sel,
   input wire logic wr_req,
   input wire logic rd_bit,
   input wire logic rd_valid,
   input wire logic rd_last,
   input wire logic busy
);
   logic [7:0] cnt_r;
   logic       sel_r;
   always_ff @(posedge mclk) begin
      cnt_r <= (nrst && rd_valid) ? cnt_r + 8'h01 : 8'h00;
      sel_r <= (rd_req && !busy) ? rd_sel : sel_r;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   chk_req_answer: assert property (rd_req && !busy |=> busy ##1 rd_valid)
      else $error("read not answered");
   chk_last_pos: assert property (rd_last == (rd_valid && cnt_r == 8'h7f))
      else $error("last bit misplaced");
   chk_len_full: assert property ($fell(rd_valid) |-> $past(rd_last))
      else $error("transfer cut short");
   chk_bit0_one: assert property (rd_last |-> rd_bit)
      else $error("bit zero low");
   chk_prop_head: assert property ($rose(rd_valid) && sel_r |-> rd_bit ##1 rd_bit ##1 !rd_bit)
      else $error("layout bits wrong");
   chk_blk_code: assert property (sel_r && rd_valid && cnt_r == 8'h2c |->
      rd_bit ##1 !rd_bit ##1 !rd_bit ##1 rd_bit)
      else $error("block code wrong");
   chk_valid_busy: assert property (rd_valid |-> busy)
      else $error("data outside busy");
   chk_busy_drop: assert property ($fell(rd_valid) |-> ##[0:1] !busy)
      else $error("busy stuck");
   chk_write_none: assert property (!busy && !rd_req |=> !busy)
      else $error("write started work");
   cover property ($rose(rd_valid) && sel_r);
   cover property ($rose(rd_valid) && !sel_r);
   cover property (busy && rd_req);
endmodule : cisd_monitor
bind cisd_regs cisd_monitor u_cisd_monitor (.mclk(mclk), .nrst(nrst), .rd_req(rd_req),
   .rd_sel(rd_sel), .wr_req(wr_req), .rd_bit(rd_bit), .rd_valid(rd_valid),
   .rd_last(rd_last), .busy(busy));
`default_nettype wire

// File: verification/cisd_host_model.sv
/* host side: gathers shifted register bits into a word.
 assumes msb-first bits qualified by rd_valid. */
`timescale 1ns/100ps
`default_nettype none
module cisd_host_model
   import cisd_pkg::*;
(
   input  wire logic mclk,
   input  wire logic rd_bit,
   input  wire logic rd_valid,
   input  wire logic rd_last,
   output var  cisd_reg_t word,
   output var  logic done
);
   always_ff @(posedge mclk) begin
      if (rd_valid) word <= {word[126:0], rd_bit};
      done <= rd_last;
   end
endmodule : cisd_host_model
`default_nettype wire

// File: verification/test_card_ident_and_specific_data_regs.sv
/* self-checking bench for the register bank.
 assumes the package and defines header are compiled first. */
`timescale 1ns/100ps
`default_nettype none
`define TB_CMP(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
   $display("mismatch %0t %h %h", $time, a, b); end end
module test_card_ident_and_specific_data_regs
   import cisd_pkg::*;
;
   // arbitrary identity values
   localparam cisd_reg_t ID_RAW = {8'ha5, 6'h00, 2'h3, 8'h66, 48'h71_72_73_74_75_76,
      8'h21, 32'h1234_5678, 8'h9c, 8'h00};
   localparam cisd_reg_t PROPS = {2'h3, 4'h4, 2'h0, 8'h4f, 8'h01, 8'h32, 12'h8f5, 4'h9,
      6'h00, 12'hfff, 15'h7fff, 5'h0f, 5'h1f, 5'h0f, 1'h1, 2'h0, 3'h2, 4'h9, 22'h0};
   logic      mclk, nrst, rd_req, rd_sel, wr_req, rd_bit, rd_valid, rd_last, busy, done;
   cisd_reg_t word, exp_word;
   cisd_reg_t q[$];
   int        bad_count, cmp_count, cyc;
   function automatic cisd_reg_t seal(cisd_reg_t v);
      logic [6:0] c;
      c = 7'h00;
      for (int i = 127; i >= 8; i--) c = {c[5:0], 1'h0} ^ ((c[6] ^ v[i]) ? 7'h09 : 7'h00);
      return {v[127:8], c, 1'h1};
   endfunction : seal
   task complete_run;
      if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : complete_run
   cisd_regs #(.LARGE_PART(1'h0), .MAKER_CODE(ID_RAW[127:120]), .PKG_TYPE(ID_RAW[113:112]),
      .OEM_CODE(ID_RAW[111:104]), .PRODUCT(ID_RAW[103:56]), .REVISION(ID_RAW[55:48]),
      .SERIAL(ID_RAW[47:16]), .MFG_DATE(ID_RAW[15:8])) u_cisd_regs (.mclk(mclk),
      .nrst(nrst), .rd_req(rd_req), .rd_sel(rd_sel), .wr_req(wr_req), .rd_bit(rd_bit),
      .rd_valid(rd_valid), .rd_last(rd_last), .busy(busy));
   cisd_host_model u_cisd_host_model (.mclk(mclk), .rd_bit(rd_bit), .rd_valid(rd_valid),
      .rd_last(rd_last), .word(word), .done(done));
   initial begin
      mclk = 1'h0;
      forever #12.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc++;
      if (done) begin
         exp_word = q.pop_front();
         `TB_CMP(word, exp_word) // word
      end
      if (cyc == 3000) begin
         bad_count++;
         complete_run();
      end
   end
   initial begin
      nrst = 1'h0;
      rd_req = 1'h0;
      rd_sel = 1'h0;
      wr_req = 1'h0;
      void'($urandom(32'h8124));
      repeat (4) @(negedge mclk);
      nrst = 1'h1;
      for (int n = 0; n < 8; n++) begin
         @(negedge mclk);
         while (busy) begin
            wr_req = 1'($urandom);
            @(negedge mclk);
         end
         rd_sel = (n < 2) ? n[0] : 1'($urandom);
         q.push_back(rd_sel ? seal(PROPS) : seal(ID_RAW));
         rd_req = 1'h1;
         repeat (2) @(negedge mclk);
         rd_req = 1'h0;
         repeat (100) begin
            @(negedge mclk);
            rd_req = 1'($urandom);
            rd_sel = 1'($urandom);
            wr_req = 1'($urandom);
         end
         @(negedge mclk);
         rd_req = 1'h0;
      end
      repeat (140) @(negedge mclk);
      `TB_CMP(q.size(), 0) // no lost or extra transfer
      complete_run();
   end
endmodule : test_card_ident_and_specific_data_regs
`default_nettype wire
